// ---- drive_seq_pkg.sv ----
// Package holding the state codes, command and status carriers of the drive sequencer.
package drive_seq_pkg;

  // ****************************************************************
  // Sequencing state codes as reported to the outside.
  // ****************************************************************
  localparam logic [2:0] CODE_NOT_READY      = 3'h0;
  localparam logic [2:0] CODE_SWITCH_DIS     = 3'h1;
  localparam logic [2:0] CODE_READY          = 3'h2;
  localparam logic [2:0] CODE_SWITCHED_ON    = 3'h3;
  localparam logic [2:0] CODE_OP_ENABLED     = 3'h4;
  localparam logic [2:0] CODE_QUICK_STOP     = 3'h5;
  localparam logic [2:0] CODE_FAULT_REACTION = 3'h6;
  localparam logic [2:0] CODE_FAULTED        = 3'h7;

  // ****************************************************************
  // Pending request bit positions and reset values.
  // ****************************************************************
  localparam int         PEND_STOP     = 0;
  localparam int         PEND_SHUTDOWN = 1;
  localparam int         PEND_COUNT    = 2;
  localparam logic [1:0] PEND_RESET    = 2'h0;

  // Sequencer states, declaration order matches the reported codes.
  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SWITCH_DIS,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QUICK_STOP,
    ST_FAULT_REACTION,
    ST_FAULTED
  } seq_state_t;

  // Decoded single-cycle commands from the controller or local signals.
  typedef struct packed {
    logic shutdown;
    logic switch_on;
    logic disable_voltage;
    logic quick_stop;
    logic enable_operation;
    logic disable_operation;
    logic fault_reset;
  } seq_cmd_t;

  // Completion levels from the stop, shutdown, quick stop and fault reaction functions.
  typedef struct packed {
    logic stop_done;
    logic shutdown_done;
    logic quick_stop_done;
    logic fault_reaction_done;
  } seq_done_t;

  // Registered outputs of the sequencer.
  typedef struct packed {
    logic [2:0] state_code;
    logic       motor_voltage_en;
    logic       ramp_en;
    logic       power_stage_ready;
    logic       fast_stop_run;
    logic       stop_run;
    logic       shutdown_run;
    logic       fault_reaction_run;
  } seq_out_t;

endpackage : drive_seq_pkg

// ---- pending_latch.sv ----
// Bank of sticky request bits where a set beats a clear in the same cycle.
`timescale 1ns/1ps
module pending_latch #(
  parameter int         WIDTH     = 2,
  parameter logic [1:0] RESET_VAL = drive_seq_pkg::PEND_RESET
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clear,
  output logic      [WIDTH-1:0] pend
);

  logic [WIDTH-1:0] next_pend;

  // ****************************************************************
  // Next value per bit.
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // A set arriving with a clear is kept so the request is not lost.
      always_comb
      begin
        next_pend[i] = set[i] | (pend[i] & ~clear[i]);
      end
    end
  endgenerate

  // Registers the request bits.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend <= RESET_VAL[WIDTH-1:0];
    else
      pend <= next_pend;
  end

endmodule : pending_latch

// ---- drive_sequencing_fsm.sv ----
// Drive power-state sequencer with fault handling and stop/shutdown completion.
//
// Summary of operation
// - Report state as enumerated code 0 to 7.
// - Power-up enters not ready to switch on.
// - Not ready leaves automatically once initialised.
// - Shutdown moves switch-on disabled to ready.
// - Switch on moves ready to switched on.
// - Enable operation moves switched on to enabled.
// - Stop returns to switched on after completion.
// - Shutdown moves switched on back to ready.
// - Quick stop or disable voltage: ready to disabled.
// - Shutdown from enabled waits for shutdown completion.
// - Ramp active in operation enabled.
// - Motor voltage applied only in operation enabled.
// - Switch on ignored when disabled, accepted when ready.
// - Stay enabled while stop or shutdown runs.
// - Quick stop active performs emergency fast stop.
// - Trip in any state except fault reaction and faulted enters fault reaction.
// - Fault reaction ends on completion or disable voltage.
// - Fault reset clears fault when none remain.
// - Quick stop in enabled enters quick stop.
`timescale 1ns/1ps
module drive_sequencing_fsm (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    init_done,
  input  wire logic                    trip,
  input  wire logic                    fault_active,
  input  wire drive_seq_pkg::seq_cmd_t cmd,
  input  wire drive_seq_pkg::seq_done_t done,
  output drive_seq_pkg::seq_out_t      out
);

  // ****************************************************************
  // State and pending request registers.
  // ****************************************************************
  drive_seq_pkg::seq_state_t state;
  drive_seq_pkg::seq_state_t next_state;
  drive_seq_pkg::seq_out_t   next_out;
  logic [drive_seq_pkg::PEND_COUNT-1:0] pend;
  logic [drive_seq_pkg::PEND_COUNT-1:0] pend_set;
  logic [drive_seq_pkg::PEND_COUNT-1:0] pend_clear;
  logic                                 stop_req;
  logic                                 shutdown_req;

  // Requests seen now or held from an earlier cycle.
  assign stop_req     = pend[drive_seq_pkg::PEND_STOP] | cmd.disable_operation;
  assign shutdown_req = pend[drive_seq_pkg::PEND_SHUTDOWN] | cmd.shutdown;

  // ****************************************************************
  // Pending stop and shutdown requests while operation is enabled.
  // ****************************************************************
  // A pulse in operation enabled is remembered until the state leaves operation enabled.
  always_comb
  begin
    pend_set   = '0;
    pend_clear = '0;
    if (state == drive_seq_pkg::ST_OP_ENABLED && !trip)
    begin
      pend_set[drive_seq_pkg::PEND_STOP]     = cmd.disable_operation;
      pend_set[drive_seq_pkg::PEND_SHUTDOWN] = cmd.shutdown;
    end
    if (next_state != drive_seq_pkg::ST_OP_ENABLED)
    begin
      pend_clear = '1;
      pend_set   = '0;
    end
  end

  pending_latch #(
    .WIDTH     (drive_seq_pkg::PEND_COUNT),
    .RESET_VAL (drive_seq_pkg::PEND_RESET)
  ) u_pending (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set     (pend_set),
    .clear   (pend_clear),
    .pend    (pend)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // Trip is checked first; every other branch yields at most one transition.
  always_comb
  begin
    next_state = state;
    if (trip && state != drive_seq_pkg::ST_FAULT_REACTION && state != drive_seq_pkg::ST_FAULTED)
      next_state = drive_seq_pkg::ST_FAULT_REACTION;
    else
    begin
      case (state)
        drive_seq_pkg::ST_NOT_READY:
        begin
          if (init_done)
            next_state = drive_seq_pkg::ST_SWITCH_DIS;
        end
        drive_seq_pkg::ST_SWITCH_DIS:
        begin
          // Switch on alone does nothing here.
          if (cmd.shutdown)
            next_state = drive_seq_pkg::ST_READY;
        end
        drive_seq_pkg::ST_READY:
        begin
          if (cmd.quick_stop || cmd.disable_voltage)
            next_state = drive_seq_pkg::ST_SWITCH_DIS;
          else if (cmd.switch_on)
            next_state = drive_seq_pkg::ST_SWITCHED_ON;
        end
        drive_seq_pkg::ST_SWITCHED_ON:
        begin
          if (cmd.quick_stop || cmd.disable_voltage)
            next_state = drive_seq_pkg::ST_SWITCH_DIS;
          else if (cmd.shutdown)
            next_state = drive_seq_pkg::ST_READY;
          else if (cmd.enable_operation)
            next_state = drive_seq_pkg::ST_OP_ENABLED;
        end
        drive_seq_pkg::ST_OP_ENABLED:
        begin
          // Stop and shutdown leave only once their function completes.
          if (cmd.disable_voltage)
            next_state = drive_seq_pkg::ST_SWITCH_DIS;
          else if (cmd.quick_stop)
            next_state = drive_seq_pkg::ST_QUICK_STOP;
          else if (shutdown_req && done.shutdown_done)
            next_state = drive_seq_pkg::ST_READY;
          else if (stop_req && done.stop_done)
            next_state = drive_seq_pkg::ST_SWITCHED_ON;
        end
        drive_seq_pkg::ST_QUICK_STOP:
        begin
          if (done.quick_stop_done || cmd.disable_voltage)
            next_state = drive_seq_pkg::ST_SWITCH_DIS;
        end
        drive_seq_pkg::ST_FAULT_REACTION:
        begin
          if (done.fault_reaction_done || cmd.disable_voltage)
            next_state = drive_seq_pkg::ST_FAULTED;
        end
        drive_seq_pkg::ST_FAULTED:
        begin
          if (cmd.fault_reset && !fault_active && !trip)
            next_state = drive_seq_pkg::ST_SWITCH_DIS;
        end
        default:
        begin
          next_state = drive_seq_pkg::ST_NOT_READY;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output decode from the next state.
  // ****************************************************************
  // Outputs are decoded ahead so they register together with the state.
  always_comb
  begin
    next_out                    = '0;
    next_out.state_code         = drive_seq_pkg::CODE_NOT_READY;
    case (next_state)
      drive_seq_pkg::ST_NOT_READY:      next_out.state_code = drive_seq_pkg::CODE_NOT_READY;
      drive_seq_pkg::ST_SWITCH_DIS:     next_out.state_code = drive_seq_pkg::CODE_SWITCH_DIS;
      drive_seq_pkg::ST_READY:          next_out.state_code = drive_seq_pkg::CODE_READY;
      drive_seq_pkg::ST_SWITCHED_ON:    next_out.state_code = drive_seq_pkg::CODE_SWITCHED_ON;
      drive_seq_pkg::ST_OP_ENABLED:     next_out.state_code = drive_seq_pkg::CODE_OP_ENABLED;
      drive_seq_pkg::ST_QUICK_STOP:     next_out.state_code = drive_seq_pkg::CODE_QUICK_STOP;
      drive_seq_pkg::ST_FAULT_REACTION: next_out.state_code = drive_seq_pkg::CODE_FAULT_REACTION;
      drive_seq_pkg::ST_FAULTED:        next_out.state_code = drive_seq_pkg::CODE_FAULTED;
      default:                          next_out.state_code = drive_seq_pkg::CODE_NOT_READY;
    endcase
    // The power stage is readied in switched on, voltage only when enabled.
    next_out.power_stage_ready  = (next_state == drive_seq_pkg::ST_SWITCHED_ON) ||
                                  (next_state == drive_seq_pkg::ST_OP_ENABLED);
    next_out.motor_voltage_en   = (next_state == drive_seq_pkg::ST_OP_ENABLED);
    next_out.ramp_en            = (next_state == drive_seq_pkg::ST_OP_ENABLED);
    next_out.fast_stop_run      = (next_state == drive_seq_pkg::ST_QUICK_STOP);
    next_out.fault_reaction_run = (next_state == drive_seq_pkg::ST_FAULT_REACTION);
    // Stop and shutdown functions run while their request is held.
    if (next_state == drive_seq_pkg::ST_OP_ENABLED && state == drive_seq_pkg::ST_OP_ENABLED)
    begin
      next_out.stop_run     = stop_req;
      next_out.shutdown_run = shutdown_req;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  // Reset lands in not ready to switch on with all enables off.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= drive_seq_pkg::ST_NOT_READY;
      out   <= '0;
    end
    else
    begin
      state <= next_state;
      out   <= next_out;
    end
  end

endmodule : drive_sequencing_fsm

// ---- drive_sequencing_fsm_asserts.sv ----
// Checker watching the drive sequencer ports.
`timescale 1ns/1ps
module drive_sequencing_fsm_asserts (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    init_done,
  input wire logic                    trip,
  input wire logic                    fault_active,
  input wire drive_seq_pkg::seq_cmd_t  cmd,
  input wire drive_seq_pkg::seq_done_t done,
  input wire drive_seq_pkg::seq_out_t  out
);
  // All checks share the system clock and its reset.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Output enables follow the reported state.
  AST_VOLT_ONLY_RUN: assert property (out.motor_voltage_en == (out.state_code == 3'h4) &&
    out.power_stage_ready == (out.state_code inside {3'h3, 3'h4})) else $error("motor voltage outside run");
  AST_RAMP_FROM_ON: assert property ($rose(out.ramp_en) |->
    out.state_code == 3'h4 && $past(out.state_code) == 3'h3) else $error("ramp start bad");
  AST_FAST_STOP: assert property (out.state_code == 3'h5 |-> out.fast_stop_run && !out.motor_voltage_en)
    else $error("fast stop not running");
  // State moves taken one edge after their cause.
  AST_INIT_LEAVE: assert property (out.state_code == 3'h0 && init_done && !trip |=> out.state_code == 3'h1)
    else $error("init not left");
  AST_DIS_SHUTDOWN: assert property (out.state_code == 3'h1 && cmd == 7'h40 && !trip |=> out.state_code == 3'h2)
    else $error("shutdown not taken");
  AST_DIS_REFUSE_ON: assert property (out.state_code == 3'h1 && cmd == 7'h20 && !trip |=> out.state_code == 3'h1)
    else $error("switch on taken while disabled");
  AST_READY_ON: assert property (out.state_code == 3'h2 && cmd == 7'h20 && !trip |=> out.state_code == 3'h3)
    else $error("switch on not taken");
  AST_RUN_HOLD: assert property (out.state_code == 3'h4 && cmd == 7'h00 && !trip && !done.stop_done &&
    !done.shutdown_done |=> out.state_code == 3'h4) else $error("run left early");
  AST_STOP_EXIT: assert property (out.state_code == 3'h4 && out.stop_run && !out.shutdown_run && done.stop_done &&
    cmd == 7'h00 && !trip |=> out.state_code == 3'h3) else $error("stop exit missed");
  AST_SHUT_EXIT: assert property (out.state_code == 3'h4 && out.shutdown_run && done.shutdown_done &&
    cmd == 7'h00 && !trip |=> out.state_code == 3'h2) else $error("shutdown exit missed");
  AST_QUICK: assert property (out.state_code == 3'h4 && cmd == 7'h08 && !trip |=> out.state_code == 3'h5)
    else $error("quick stop missed");
  AST_TRIP: assert property (trip && out.state_code < 3'h6 |=> out.state_code == 3'h6)
    else $error("trip missed");
  AST_REACT_DONE: assert property (out.state_code == 3'h6 && done.fault_reaction_done |=> out.state_code == 3'h7)
    else $error("fault reaction end missed");
  AST_RESET_BLOCK: assert property (out.state_code == 3'h7 && fault_active |=> out.state_code == 3'h7)
    else $error("fault cleared while active");
endmodule : drive_sequencing_fsm_asserts

// ---- drive_far_side.sv ----
// Model of the stop, shutdown, quick stop and fault reaction functions.
`timescale 1ns/1ps
module drive_far_side (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire drive_seq_pkg::seq_out_t out,
  input  wire logic [2:0]              dly,
  output drive_seq_pkg::seq_done_t     done
);
  logic [3:0] busy_cnt;
  logic       busy;
  // A function is busy while the sequencer asks it to run.
  assign busy = out.stop_run | out.shutdown_run | out.fast_stop_run | out.fault_reaction_run;
  // Counts run cycles; saturates so a long run never wraps to early completion.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_cnt <= 4'h0;
    else if (!busy)
      busy_cnt <= 4'h0;
    else if (busy_cnt != 4'hF)
      busy_cnt <= busy_cnt + 4'h1;
  end
  // Completion levels rise after the delay and drop with the request.
  assign done = {out.stop_run, out.shutdown_run, out.fast_stop_run, out.fault_reaction_run} &
                {4{busy_cnt >= {1'b0, dly}}};
endmodule : drive_far_side

// ---- test_drive_sequencing_fsm.sv ----
// Self-checking testbench of the drive sequencer.
`timescale 1ns/1ps
module test_drive_sequencing_fsm;
  logic                     clk, sys_rst, init_done, trip, fault_active;
  logic [2:0]               dly, prev_code;
  logic [2:0]               exp_q[$];
  drive_seq_pkg::seq_cmd_t  cmd;
  drive_seq_pkg::seq_done_t done;
  drive_seq_pkg::seq_out_t  out;
  int                       n_mismatch, n_checks, seed, r, k;

  drive_sequencing_fsm DUT (.clk(clk), .sys_rst(sys_rst), .init_done(init_done), .trip(trip),
    .fault_active(fault_active), .cmd(cmd), .done(done), .out(out));
  drive_far_side u_far (.clk(clk), .sys_rst(sys_rst), .out(out), .dly(dly), .done(done));

  // Clock of 100 ns period.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Presents one command pulse for a single edge.
  task automatic send(input drive_seq_pkg::seq_cmd_t c);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask : send

  // Notes one expected state, presents its command and waits until it is seen.
  task automatic step(input logic [2:0] code, input drive_seq_pkg::seq_cmd_t c);
    exp_q.push_back(code);
    send(c);
    settle;
  endtask : step

  // Waits, bounded, until every noted state has been seen.
  task automatic settle;
    int i;
    @(posedge clk);
    for (i = 0; i < 40 && exp_q.size() != 0; i++)
      @(posedge clk);
    if (exp_q.size() != 0)
    begin
      check("state reached", out.state_code, exp_q[0]);
      exp_q.delete();
    end
  endtask : settle

  // Every change of reported state takes the oldest note off the queue.
  always @(negedge clk)
  begin
    if (!sys_rst && out.state_code !== prev_code)
    begin
      if (exp_q.size() == 0)
        check("unrequested move", out.state_code, prev_code);
      else
        check("state", out.state_code, exp_q.pop_front());
      // The fast stop and fault reaction functions run only in their own states.
      check("function runs", {1'b0, out.fast_stop_run, out.fault_reaction_run},
        {1'b0, out.state_code == 3'h5, out.state_code == 3'h6});
    end
    prev_code = out.state_code;
  end

  // Main sequence through the power states.
  initial
  begin
    seed = 44;
    prev_code = 3'h0;
    {sys_rst, init_done, trip, fault_active, dly, cmd} = {1'b1, 13'h0000};
    repeat (4) @(posedge clk);
    check("reset state", out.state_code, 3'h0);
    sys_rst <= 1'b0;
    exp_q.push_back(3'h1);
    init_done <= 1'b1;
    settle;
    send(7'h20);
    settle;
    for (k = 0; k < 2; k++)
    begin
      step(3'h2, 7'h40);
      step(3'h1, k == 0 ? 7'h08 : 7'h10);
    end
    // Walk ready, switched on, ready, switched on and then operation enabled.
    for (k = 0; k < 5; k++)
      step(k == 4 ? 3'h4 : (k % 2 == 0 ? 3'h2 : 3'h3), k == 4 ? 7'h04 : (k % 2 == 0 ? 7'h40 : 7'h20));
    check("run enables", {out.motor_voltage_en, out.ramp_en, out.power_stage_ready}, 3'h7);
    for (k = 0; k < 2; k++)
    begin
      r = $random(seed);
      dly <= r[2:0] | 3'h2;
      exp_q.push_back(k == 0 ? 3'h3 : 3'h2);
      send(k == 0 ? 7'h02 : 7'h40);
      @(negedge clk);
      check("run flags", {1'b0, out.stop_run, out.shutdown_run}, k == 0 ? 3'h2 : 3'h1);
      settle;
      if (k == 1)
        step(3'h3, 7'h20);
      step(3'h4, 7'h04);
    end
    exp_q = {3'h5, 3'h1};
    send(7'h08);
    settle;
    step(3'h2, 7'h40);
    exp_q = {3'h6, 3'h7};
    trip <= 1'b1;
    fault_active <= 1'b1;
    send(7'h20);
    trip <= 1'b0;
    settle;
    send(7'h01);
    settle;
    fault_active <= 1'b0;
    step(3'h1, 7'h01);
    end_of_test;
  end

  // Watchdog against a hang.
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule : test_drive_sequencing_fsm

bind drive_sequencing_fsm drive_sequencing_fsm_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .init_done(init_done),
  .trip(trip), .fault_active(fault_active), .cmd(cmd), .done(done), .out(out));
